// >>> common/saf_pkg.sv
package saf_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ            = 50_000_000;
  localparam int CONV_CYCLES       = 2;
  localparam int SCLK_PERIOD_MCLK  = 1;
  localparam int SEN_HIGH_MIN_MCLK = 3;
  localparam int SCLK_HALF_DEF     = 4;
  localparam int REF_DELAY_MIN     = 1;
  localparam int REF_DELAY_MAX     = 4;
  // ---------------------------------------------------------------
  // device configuration registers
  // ---------------------------------------------------------------
  localparam int         REG_COUNT       = 11;
  localparam logic [3:0] REG_SAMPLE_MODE = 4'h0;
  localparam logic [3:0] REG_COLOR_MODE  = 4'h7;
  localparam logic [3:0] REG_TEST1       = 4'h9;
  localparam logic [7:0] SAMPLE_MODE_RST = 8'h62;
  localparam logic [7:0] TEST1_RST       = 8'h10;
  localparam logic [7:0] OTHER_RST       = 8'h00;
  localparam int         BIT_DBL_SAMPLE  = 5;
  localparam int         BIT_POLARITY    = 4;
  localparam int         REF_SEL_LO      = 1;
  localparam int         REF_SEL_HI      = 2;
  // ---------------------------------------------------------------
  // serial frame
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 13;
  localparam int FRAME_RW   = 12;
  localparam int READ_BITS  = 8;
  localparam int RESULT_W   = 16;
  localparam int BYTE_W     = 8;
  // ---------------------------------------------------------------
  // controller registers (axi4-lite byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_DIV    = 8'h04;
  localparam logic [7:0]  ADDR_SER    = 8'h08;
  localparam logic [7:0]  ADDR_STAT   = 8'h0C;
  localparam logic [7:0]  ADDR_PIXEL  = 8'h10;
  localparam int          CTRL_RUN    = 0;
  localparam int          CTRL_CLAMP  = 1;
  localparam logic [7:0]  DIV_RST     = 8'h06;
  localparam logic [7:0]  DIV_MIN     = 8'h02;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef logic [RESULT_W-1:0] saf_word_t;

  function automatic logic [7:0] saf_reg_rst(input int idx);
    if (idx == int'(REG_SAMPLE_MODE)) begin
      return SAMPLE_MODE_RST;
    end
    if (idx == int'(REG_TEST1)) begin
      return TEST1_RST;
    end
    return OTHER_RST;
  endfunction : saf_reg_rst
endpackage : saf_pkg

// >>> common/saf_link_if.sv
`timescale 1ns/1ps
interface saf_link_if;
  logic       sample_strobe;
  logic       clamp_strobe;
  logic       shift_clock;
  logic       shift_enable_n;
  logic       serial_in;
  logic       serial_out;
  logic [7:0] pixel_byte_bus;
  logic       pixel_byte_valid;
  logic       pixel_byte_high;

  modport dev (
    input  sample_strobe, clamp_strobe, shift_clock, shift_enable_n, serial_in,
    output serial_out, pixel_byte_bus, pixel_byte_valid, pixel_byte_high
  );
  modport ctl (
    output sample_strobe, clamp_strobe, shift_clock, shift_enable_n, serial_in,
    input  serial_out, pixel_byte_bus, pixel_byte_valid, pixel_byte_high
  );
endinterface : saf_link_if

// >>> verilog/saf_afe_dev.sv
`timescale 1ns/1ps
module saf_afe_dev #(
  parameter saf_pkg::saf_word_t VREF_HI = 16'hFFFF,
  parameter saf_pkg::saf_word_t VREF_LO = 16'h0000,
  parameter saf_pkg::saf_word_t INT_REF = 16'h0000
) (
  input  wire logic               clock_i,
  input  wire logic               rst_i,
  saf_link_if.dev                 link,
  input  wire saf_pkg::saf_word_t analog_pixel_input_i [3],
  input  wire saf_pkg::saf_word_t reference_level_i,
  output logic                    clamp_active_o,
  output saf_pkg::saf_word_t      clamp_level_o,
  output logic [7:0]              sample_mode_o,
  output logic [7:0]              color_mode_o
);
  import saf_pkg::*;

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [7:0]            cfg [REG_COUNT];
  logic                  sclk_q;
  logic                  sen_q;
  logic                  sclk_rise;
  logic                  sclk_fall;
  logic                  sen_rise;
  logic                  sen_fall;
  logic [FRAME_BITS-1:0] shift_in;
  logic [3:0]            fr_addr;
  logic                  fr_mapped;

  // strobes come from logic on clock_i, so they are read unsynchronised;
  // the shift clock must stay at least one clock high and at least two clocks low
  assign sclk_rise = link.shift_clock & ~sclk_q;
  assign sclk_fall = ~link.shift_clock & sclk_q;
  assign sen_rise  = link.shift_enable_n & ~sen_q;
  assign sen_fall  = ~link.shift_enable_n & sen_q;
  assign fr_addr   = shift_in[FRAME_RW-1:READ_BITS];
  assign fr_mapped = fr_addr < 4'(REG_COUNT);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sclk_q <= 1'b0;
      sen_q  <= 1'b1;
    end else begin
      sclk_q <= link.shift_clock;
      sen_q  <= link.shift_enable_n;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      shift_in <= '0;
    end else if (!link.shift_enable_n && sclk_rise) begin
      shift_in <= {shift_in[FRAME_BITS-2:0], link.serial_in};
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        cfg[i] <= saf_reg_rst(i);
      end
    end else if (sen_rise && !shift_in[FRAME_RW] && fr_mapped) begin
      cfg[fr_addr] <= shift_in[READ_BITS-1:0];
    end
  end

  assign sample_mode_o = cfg[REG_SAMPLE_MODE];
  assign color_mode_o  = cfg[REG_COLOR_MODE];

  // ---------------------------------------------------------------
  // serial read-back
  // ---------------------------------------------------------------
  logic [7:0] read_buf;
  logic       read_armed;
  logic       read_active;
  logic [3:0] out_cnt;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      read_buf   <= 8'h00;
      read_armed <= 1'b0;
    end else if (sen_rise) begin
      read_armed <= shift_in[FRAME_RW];
      if (shift_in[FRAME_RW]) begin
        read_buf <= fr_mapped ? cfg[fr_addr] : 8'h00;
      end
    end else if (sen_fall) begin
      read_armed <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      read_active     <= 1'b0;
      out_cnt         <= 4'h0;
      link.serial_out <= 1'b0;
    end else if (sen_fall) begin
      read_active     <= read_armed;
      out_cnt         <= 4'h0;
      link.serial_out <= 1'b0;
    end else if (read_active && !link.shift_enable_n && sclk_fall
                 && out_cnt < 4'(READ_BITS)) begin
      link.serial_out <= read_buf[3'(READ_BITS - 1) - out_cnt[2:0]];
      out_cnt         <= out_cnt + 4'h1;
    end else if (sen_rise) begin
      read_active <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // sampling
  // ---------------------------------------------------------------
  logic      strobe_seen;
  logic      clamp_req;
  logic      clamp_active;
  logic [2:0] ref_cnt;
  saf_word_t pix [3];
  saf_word_t clamp_level;
  logic      polarity;
  logic      dbl_sample;
  logic [1:0] ref_sel;

  assign polarity    = cfg[REG_SAMPLE_MODE][BIT_POLARITY];
  assign dbl_sample  = cfg[REG_SAMPLE_MODE][BIT_DBL_SAMPLE];
  assign ref_sel     = cfg[REG_SAMPLE_MODE][REF_SEL_HI:REF_SEL_LO];
  assign clamp_level = polarity ? VREF_HI : VREF_LO;
  assign clamp_level_o  = clamp_level;
  assign clamp_active_o = clamp_active;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      strobe_seen <= 1'b0;
      clamp_req   <= 1'b0;
    end else begin
      strobe_seen <= link.sample_strobe;
      clamp_req   <= link.sample_strobe & link.clamp_strobe;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      clamp_active <= 1'b0;
    end else if (strobe_seen) begin
      clamp_active <= clamp_req;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      for (int c = 0; c < 3; c++) begin
        pix[c] <= '0;
      end
    end else if (strobe_seen) begin
      for (int c = 0; c < 3; c++) begin
        pix[c] <= clamp_req ? clamp_level : analog_pixel_input_i[c];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ref_cnt <= 3'h0;
    end else if (strobe_seen) begin
      ref_cnt <= 3'(REF_DELAY_MIN) + {1'b0, ref_sel};
    end else if (ref_cnt != 3'h0) begin
      ref_cnt <= ref_cnt - 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // conversion and byte output
  // ---------------------------------------------------------------
  function automatic saf_word_t conv(input saf_word_t s, input saf_word_t r,
                                     input logic pos);
    saf_word_t a;
    saf_word_t b;
    a = pos ? s : r;
    b = pos ? r : s;
    return (a > b) ? saf_word_t'(a - b) : '0;
  endfunction : conv

  saf_word_t res [3];
  saf_word_t ref_now;
  logic      start;
  logic [1:0] ch;
  logic [1:0] left;
  logic      low_phase;
  logic [1:0] cmode;

  assign start = (ref_cnt == 3'h1);
  assign cmode = cfg[REG_COLOR_MODE][1:0];
  assign ref_now = !dbl_sample ? INT_REF :
                   clamp_active ? clamp_level : reference_level_i;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      for (int c = 0; c < 3; c++) begin
        res[c] <= '0;
      end
    end else if (start) begin
      for (int c = 0; c < 3; c++) begin
        res[c] <= conv(pix[c], ref_now, polarity);
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ch        <= 2'h0;
      left      <= 2'h0;
      low_phase <= 1'b0;
    end else if (start) begin
      ch        <= (cmode == 2'h0) ? 2'h0 : cmode - 2'h1;
      left      <= (cmode == 2'h0) ? 2'h3 : 2'h1;
      low_phase <= 1'b0;
    end else if (left != 2'h0) begin
      low_phase <= ~low_phase;
      if (low_phase) begin
        ch   <= ch + 2'h1;
        left <= left - 2'h1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      link.pixel_byte_bus   <= 8'h00;
      link.pixel_byte_valid <= 1'b0;
      link.pixel_byte_high  <= 1'b0;
    end else if (left != 2'h0 && !start) begin
      link.pixel_byte_valid <= 1'b1;
      link.pixel_byte_high  <= ~low_phase;
      link.pixel_byte_bus   <= low_phase ? res[ch][BYTE_W-1:0]
                                         : res[ch][RESULT_W-1:BYTE_W];
    end else begin
      link.pixel_byte_valid <= 1'b0;
      link.pixel_byte_high  <= 1'b0;
    end
  end
endmodule : saf_afe_dev

// >>> verilog/saf_afe_ctl.sv
`timescale 1ns/1ps
module saf_afe_ctl #(
  parameter int SCLK_HALF = saf_pkg::SCLK_HALF_DEF,
  parameter int SEN_GAP   = saf_pkg::SEN_HIGH_MIN_MCLK
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  saf_link_if.ctl          link,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i
);
  import saf_pkg::*;

  typedef enum logic [1:0] {SER_IDLE, SER_LOW, SER_GAP} saf_ser_t;

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic        aw_held;
  logic        w_held;
  logic        do_wr;
  logic [1:0]  ctrl;
  logic [7:0]  pix_div;
  logic [12:0] frame;
  logic        busy;
  logic [7:0]  rd_data;
  saf_word_t   pixel_word;
  logic [15:0] pixel_count;

  assign s_axi_awready_o = ~aw_held & ~s_axi_bvalid_o;
  assign s_axi_wready_o  = ~w_held & ~s_axi_bvalid_o;
  assign s_axi_arready_o = ~s_axi_rvalid_o;
  assign do_wr = aw_held & w_held & ~s_axi_bvalid_o;

  function automatic logic mapped(input logic [7:0] a);
    return a == ADDR_CTRL || a == ADDR_DIV || a == ADDR_SER ||
           a == ADDR_STAT || a == ADDR_PIXEL;
  endfunction : mapped

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      aw_held        <= 1'b0;
      w_held         <= 1'b0;
      aw_addr        <= 8'h00;
      w_data         <= 32'h0000_0000;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
      end
      if (do_wr) begin
        aw_held        <= 1'b0;
        w_held         <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // only byte lane 0 carries control and divider bits
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctrl    <= 2'h0;
      pix_div <= DIV_RST;
    end else if (do_wr && s_axi_wstrb_i[0]) begin
      if (aw_addr == ADDR_CTRL) begin
        ctrl <= w_data[1:0];
      end
      if (aw_addr == ADDR_DIV) begin
        pix_div <= (w_data[7:0] < DIV_MIN) ? DIV_MIN : w_data[7:0];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o  <= mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr_i)
        ADDR_CTRL:  s_axi_rdata_o <= {30'h0, ctrl};
        ADDR_DIV:   s_axi_rdata_o <= {24'h00_0000, pix_div};
        ADDR_SER:   s_axi_rdata_o <= {19'h0_0000, frame};
        ADDR_STAT:  s_axi_rdata_o <= {pixel_count, rd_data, 7'h00, busy};
        ADDR_PIXEL: s_axi_rdata_o <= {16'h0000, pixel_word};
        default:    s_axi_rdata_o <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // sample strobe timing
  // ---------------------------------------------------------------
  logic [7:0] div_cnt;

  always_ff @(posedge clock_i) begin
    if (rst_i || !ctrl[CTRL_RUN]) begin
      div_cnt            <= 8'h00;
      link.sample_strobe <= 1'b0;
      link.clamp_strobe  <= 1'b0;
    end else begin
      div_cnt            <= (div_cnt >= pix_div - 8'h01) ? 8'h00 : div_cnt + 8'h01;
      link.sample_strobe <= (div_cnt == 8'h00);
      link.clamp_strobe  <= (div_cnt == 8'h00) & ctrl[CTRL_CLAMP];
    end
  end

  // ---------------------------------------------------------------
  // serial port
  // ---------------------------------------------------------------
  saf_ser_t   st;
  logic [7:0] half_cnt;
  logic [3:0] bit_idx;
  logic       second;
  logic [7:0] rd_shift;
  logic       half_end;

  assign busy     = (st != SER_IDLE);
  assign half_end = (half_cnt == 8'(SCLK_HALF - 1));

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      frame <= 13'h0000;
    end else if (do_wr && aw_addr == ADDR_SER && !busy && s_axi_wstrb_i[1:0] == 2'h3) begin
      frame <= w_data[12:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st                  <= SER_IDLE;
      half_cnt            <= 8'h00;
      bit_idx             <= 4'h0;
      second              <= 1'b0;
      rd_shift            <= 8'h00;
      rd_data             <= 8'h00;
      link.shift_clock    <= 1'b0;
      link.shift_enable_n <= 1'b1;
      link.serial_in      <= 1'b0;
    end else begin
      unique case (st)
        SER_IDLE: begin
          if (do_wr && aw_addr == ADDR_SER && s_axi_wstrb_i[1:0] == 2'h3) begin
            st                  <= SER_LOW;
            second              <= 1'b0;
            bit_idx             <= 4'h0;
            half_cnt            <= 8'h00;
            link.shift_enable_n <= 1'b0;
            link.serial_in      <= w_data[FRAME_RW];
          end
        end
        SER_LOW: begin
          half_cnt <= half_end ? 8'h00 : half_cnt + 8'h01;
          if (half_end && !link.shift_clock) begin
            link.shift_clock <= 1'b1;
            if (second && bit_idx >= 4'h1 && bit_idx <= 4'(READ_BITS)) begin
              rd_shift <= {rd_shift[6:0], link.serial_out};
            end
          end else if (half_end) begin
            link.shift_clock <= 1'b0;
            if (bit_idx == 4'(FRAME_BITS - 1)) begin
              st                  <= SER_GAP;
              link.shift_enable_n <= 1'b1;
            end else begin
              bit_idx        <= bit_idx + 4'h1;
              link.serial_in <= frame[4'(FRAME_RW - 1) - bit_idx];
            end
          end
        end
        SER_GAP: begin
          half_cnt <= half_cnt + 8'h01;
          if (half_cnt >= 8'(SEN_GAP - 1)) begin
            half_cnt <= 8'h00;
            if (frame[FRAME_RW] && !second) begin
              st                  <= SER_LOW;
              second              <= 1'b1;
              bit_idx             <= 4'h0;
              link.shift_enable_n <= 1'b0;
              link.serial_in      <= frame[FRAME_RW];
            end else begin
              st <= SER_IDLE;
              if (second) begin
                rd_data <= rd_shift;
              end
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pixel reassembly
  // ---------------------------------------------------------------
  logic [7:0] hi_byte;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hi_byte     <= 8'h00;
      pixel_word  <= '0;
      pixel_count <= 16'h0000;
    end else if (link.pixel_byte_valid && link.pixel_byte_high) begin
      hi_byte <= link.pixel_byte_bus;
    end else if (link.pixel_byte_valid) begin
      pixel_word  <= {hi_byte, link.pixel_byte_bus};
      pixel_count <= pixel_count + 16'h0001;
    end
  end
endmodule : saf_afe_ctl

// >>> sim/saf_link_props.sv
`timescale 1ns/1ps
module saf_link_props (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic sample_strobe,
  input wire logic clamp_strobe,
  input wire logic shift_clock,
  input wire logic shift_enable_n,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic pixel_byte_valid,
  input wire logic pixel_byte_high
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  a_high_then_low: assert property (
    pixel_byte_valid && pixel_byte_high |=> pixel_byte_valid && !pixel_byte_high)
    else $error("low byte missing");
  a_burst_high_first: assert property (
    $rose(pixel_byte_valid) |-> pixel_byte_high) else $error("burst began low");
  // strobe at E, pixel at E+1, reference 1..4 later, first byte seen two clocks after that
  a_pixel_timing: assert property (
    sample_strobe |=> !pixel_byte_valid [*3] ##[1:4] pixel_byte_valid && pixel_byte_high)
    else $error("first byte out of window");
  a_clamp_pair: assert property (
    clamp_strobe |-> sample_strobe) else $error("clamp without sample");
  a_strobe_pulse: assert property (
    sample_strobe |=> !sample_strobe) else $error("strobe spacing below two");
  a_sclk_hold: assert property (
    $changed(shift_clock) |=> $stable(shift_clock)) else $error("shift clock too fast");
  a_enable_gap: assert property (
    $rose(shift_enable_n) |=> shift_enable_n [*2]) else $error("enable gap short");
  a_sclk_idle: assert property (
    shift_enable_n && $past(shift_enable_n) |-> !shift_clock) else $error("clock outside frame");
  a_sdi_change: assert property (
    !shift_enable_n && $changed(serial_in) |-> $fell(shift_clock) || $fell(shift_enable_n))
    else $error("serial input moved off a fall");
  // output may only move in the low half so a rising edge always sees it settled
  a_sdo_change: assert property (
    !shift_enable_n && $changed(serial_out) |-> !shift_clock) else $error("serial output late");
endmodule : saf_link_props

// >>> sim/scanner_afe_sample_and_serial_port_bench.sv
`timescale 1ns/1ps
module scanner_afe_sample_and_serial_port_bench;
  import saf_pkg::*;
  logic        clock_i     = 1'b0;
  logic        rst_i       = 1'b1;
  logic [7:0]  aw_a        = 8'h00;
  logic [7:0]  ar_a        = 8'h00;
  logic [31:0] w_d         = 32'h0000_0000;
  logic        aw_v        = 1'b0;
  logic        w_v         = 1'b0;
  logic        b_r         = 1'b0;
  logic        ar_v        = 1'b0;
  logic        r_r         = 1'b0;
  logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, clamp_act;
  logic [1:0]  b_resp, r_resp;
  logic [1:0]  b_got       = 2'h3;
  logic [31:0] r_d;
  logic [7:0]  smode, cmode;
  saf_word_t   pix [3]     = '{16'h1234, 16'h2345, 16'h3456};
  saf_word_t   ref_lvl     = 16'h0100;
  saf_word_t   clamp_lvl;
  int          error_cnt   = 0;
  int          check_count = 0;
  int          cyc         = 0;
  saf_link_if link ();
  saf_afe_dev saf_afe_dev_i (.clock_i, .rst_i, .link(link), .analog_pixel_input_i(pix),
    .reference_level_i(ref_lvl), .clamp_active_o(clamp_act), .clamp_level_o(clamp_lvl),
    .sample_mode_o(smode), .color_mode_o(cmode));
  saf_afe_ctl saf_afe_ctl_i (.clock_i, .rst_i, .link(link), .s_axi_awaddr_i(aw_a),
    .s_axi_awvalid_i(aw_v), .s_axi_awready_o(aw_rdy), .s_axi_wdata_i(w_d),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(w_v), .s_axi_wready_o(w_rdy),
    .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_r),
    .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(ar_v), .s_axi_arready_o(ar_rdy),
    .s_axi_rdata_o(r_d), .s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_v), .s_axi_rready_i(r_r));
  saf_link_props saf_link_props_i (.clock_i, .rst_i, .sample_strobe(link.sample_strobe),
    .clamp_strobe(link.clamp_strobe), .shift_clock(link.shift_clock),
    .shift_enable_n(link.shift_enable_n), .serial_in(link.serial_in),
    .serial_out(link.serial_out), .pixel_byte_valid(link.pixel_byte_valid),
    .pixel_byte_high(link.pixel_byte_high));
  initial begin
    forever #10 clock_i = ~clock_i;
  end
  // --------
  // bus tasks
  // --------
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // readies are combinational, so they are read before the edge's updates land
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    aw_a <= a;
    w_d  <= d;
    aw_v <= 1'b1;
    w_v  <= 1'b1;
    b_r  <= 1'b1;
    do begin
      @(posedge clock_i);
      if (aw_rdy) aw_v <= 1'b0;
      if (w_rdy) w_v <= 1'b0;
    end while (!(b_v && b_r));
    // bready stays up between writes, so back-to-back calls never drive it twice in a step
    b_got = b_resp;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r  <= 1'b1;
    do begin
      @(posedge clock_i);
      if (ar_rdy) ar_v <= 1'b0;
    end while (!(r_v && r_r));
    d = r_d;
    r = r_resp;
  endtask : axi_rd
  task automatic ser(input logic rw, input logic [3:0] a, input logic [7:0] d);
    logic [31:0] s;
    logic [1:0]  r;
    axi_wr(ADDR_SER, {19'h0_0000, rw, a, d});
    do axi_rd(ADDR_STAT, s, r); while (s[0] !== 1'b0);
  endtask : ser
  task automatic dev_rd(input logic [3:0] a, input logic [7:0] e);
    logic [31:0] s;
    logic [1:0]  r;
    ser(1'b1, a, 8'h00);
    axi_rd(ADDR_STAT, s, r);
    chk(s[15:8], e);
  endtask : dev_rd
  // waits for a quiet gap after at least one whole new burst, then checks the word
  task automatic pix_is(input saf_word_t e);
    logic [31:0] s0, s1, s2;
    logic [1:0]  r;
    axi_rd(ADDR_STAT, s0, r);
    do begin
      axi_rd(ADDR_STAT, s1, r);
      axi_rd(ADDR_STAT, s2, r);
    end while (s2[31:16] - s0[31:16] < 16'h0006 || s2 !== s1);
    axi_rd(ADDR_PIXEL, s0, r);
    chk(s0[15:0], e);
  endtask : pix_is
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // --------
  // tests
  // --------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    chk(smode, SAMPLE_MODE_RST);
    dev_rd(REG_SAMPLE_MODE, 8'h62);
    dev_rd(REG_TEST1, TEST1_RST);
    dev_rd(4'hB, 8'h00);
    axi_rd(8'h14, d, r);
    chk(r, RESP_SLVERR);
    axi_wr(ADDR_DIV, 32'h0000_0040);
    chk(b_got, RESP_OKAY);
    axi_wr(ADDR_CTRL, 32'h0000_0001);
    for (int m = 0; m < 4; m++) begin
      ser(1'b0, REG_COLOR_MODE, 8'(m));
      chk(cmode, 8'(m));
      for (int k = 0; k < 4; k++) begin
        ser(1'b0, REG_SAMPLE_MODE, 8'h30 + 8'(2 * k));
        pix_is(pix[(m == 0) ? 2 : m - 1] - ref_lvl);
      end
    end
    ser(1'b0, REG_SAMPLE_MODE, 8'h10);
    pix_is(pix[2]);
    ref_lvl <= 16'h4000;
    ser(1'b0, REG_SAMPLE_MODE, 8'h20);
    pix_is(16'h4000 - pix[2]);
    chk(clamp_lvl, 16'h0000);
    axi_wr(ADDR_CTRL, 32'h0000_0003);
    pix_is(16'h0000);
    chk(clamp_act, 1'b1);
    ser(1'b0, REG_SAMPLE_MODE, 8'h30);
    chk(clamp_lvl, 16'hFFFF);
    pix_is(16'h0000);
    axi_wr(ADDR_CTRL, 32'h0000_0000);
    axi_wr(8'h18, 32'h0000_0001);
    chk(b_got, RESP_SLVERR);
    axi_wr(ADDR_DIV, 32'h0000_0001);
    axi_rd(ADDR_DIV, d, r);
    chk(d, DIV_MIN);
    wrap_up();
  end
endmodule : scanner_afe_sample_and_serial_port_bench
